//--- pdfc_cfg.svh
/*
 * Timing counts and reset values for the power-down freeze control block.
 * Assumes a 200 MHz system clock; included by name where needed.
 */
// Contract
// - Sleep low captures inputs, logic and outputs.
// - Outputs hold low, high or high impedance.
// - Input and clock toggles ignored while asleep.
// - Combinational outputs follow inputs within wake delay; pins stay held through the wake state and update one cycle into run.
// - Registered outputs resume clocking within wake delay.
// - Every register has a clock enable.
// - Per-macrocell speed select bit.
// - Low-power macrocells add fixed delay.
// - Readback lock refuses reads; erase clears it.
`ifndef PDFC_CFG_SVH
`define PDFC_CFG_SVH
// Clock period in picoseconds.
`define PDFC_CLK_PERIOD_PS   5000
// Wake response delay in picoseconds, and its cycle count (longest time, rounded down).
`define PDFC_WAKE_DELAY_PS   20000
`define PDFC_WAKE_CYCLES     ((`PDFC_WAKE_DELAY_PS / `PDFC_CLK_PERIOD_PS) < 1 ? 1 : \
                              (`PDFC_WAKE_DELAY_PS / `PDFC_CLK_PERIOD_PS))
// Low-power delay adder in picoseconds, and its cycle count (least time, rounded up).
`define PDFC_LP_ADDER_PS     5000
`define PDFC_LP_CYCLES       ((`PDFC_LP_ADDER_PS + `PDFC_CLK_PERIOD_PS - 1) / `PDFC_CLK_PERIOD_PS)
// Reset values.
`define PDFC_RST_SPEED_SEL   1'b1
`define PDFC_RST_LOCK        1'b0
`endif

//--- pdfc_pkg.sv
/*
 * Types shared by the power-down freeze control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pdfc_pkg;
    // ========================================
    // Sleep sequencer states.
    typedef enum logic [3:0] {
        PDFC_RUN   = 4'b0001,
        PDFC_ENTER = 4'b0010,
        PDFC_SLEEP = 4'b0100,
        PDFC_WAKE  = 4'b1000
    } pdfc_state_type;
endpackage

//--- pdfc_cell.sv
/*
 * One macrocell: a clock-enabled register with an optional low-power
 * delay line on its data and enable path.
 * Assumes the parent supplies the freeze gate and speed select.
 */
`timescale 1ns/100ps
`include "pdfc_cfg.svh"
module pdfc_cell #(
    parameter int LP_CYCLES = `PDFC_LP_CYCLES
) (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // Control.
    input  wire logic run_en,
    input  wire logic high_speed,
    // Data.
    input  wire logic d_in,
    input  wire logic user_ce,
    output logic      q_out,
    output logic      comb_out
);
    initial begin
        if (LP_CYCLES < 1 || LP_CYCLES > 32) begin
            $error("pdfc_cell: LP_CYCLES out of range");
        end
    end

    // ========================================
    // State: delay line, registered output and held combinational value.
    typedef struct packed {
        logic [LP_CYCLES-1:0] dly_d;
        logic [LP_CYCLES-1:0] dly_ce;
        logic                 q;
        logic                 comb;
    } pdfc_cell_st_type;

    pdfc_cell_st_type st_ff;
    pdfc_cell_st_type nxt_st;
    logic             eff_d;
    logic             eff_ce;

    // Low-power cells take the data from the end of the delay line.
    always_comb begin
        eff_d  = high_speed ? d_in : st_ff.dly_d[LP_CYCLES-1];
        eff_ce = high_speed ? user_ce : st_ff.dly_ce[LP_CYCLES-1];
        nxt_st = st_ff;
        if (run_en) begin
            // The delay line freezes too, so nothing in flight leaks through sleep.
            // The size cast drops the oldest bit off the far end of each line.
            nxt_st.dly_d  = LP_CYCLES'({st_ff.dly_d, d_in});
            nxt_st.dly_ce = LP_CYCLES'({st_ff.dly_ce, user_ce});
            nxt_st.comb   = eff_d;
            if (eff_ce) begin
                nxt_st.q = eff_d;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_out    = st_ff.q;
    assign comb_out = st_ff.comb;
endmodule

//--- pdfc_top.sv
/*
 * Power-down freeze control: a bank of macrocells whose inputs, state and
 * pins freeze while the active-low sleep request is low, with wake delay,
 * per-cell speed select and a readback lock cleared on erase.
 * Assumes the board controller sequences clocks and enables around sleep.
 */
`timescale 1ns/100ps
`include "pdfc_cfg.svh"
module pdfc_top #(
    parameter int N_CELLS     = 8,
    parameter int WAKE_CYCLES = `PDFC_WAKE_CYCLES
) (
    // Clock and reset.
    clk_sys,
    rst,
    // Sleep and tristate controls.
    sleep_request_n,
    tristate_control_a_n,
    tristate_control_b_n,
    // User logic pins.
    user_in,
    user_ce,
    oe_sel_b,
    pin_out,
    pin_oe,
    // Configuration.
    cfg_wr,
    cfg_speed_sel,
    cfg_lock_set,
    cfg_erase,
    cfg_rd,
    cfg_rd_data,
    cfg_rd_valid,
    cfg_rd_refused,
    // Status.
    asleep
);
    input  wire logic               clk_sys;
    input  wire logic               rst;
    input  wire logic               sleep_request_n;
    input  wire logic               tristate_control_a_n;
    input  wire logic               tristate_control_b_n;
    input  wire logic [N_CELLS-1:0] user_in;
    input  wire logic [N_CELLS-1:0] user_ce;
    input  wire logic [N_CELLS-1:0] oe_sel_b;
    output logic      [N_CELLS-1:0] pin_out;
    output logic      [N_CELLS-1:0] pin_oe;
    input  wire logic               cfg_wr;
    input  wire logic [N_CELLS-1:0] cfg_speed_sel;
    input  wire logic               cfg_lock_set;
    input  wire logic               cfg_erase;
    input  wire logic               cfg_rd;
    output logic      [N_CELLS-1:0] cfg_rd_data;
    output logic                    cfg_rd_valid;
    output logic                    cfg_rd_refused;
    output logic                    asleep;

    initial begin
        if (N_CELLS < 1 || N_CELLS > 64 || WAKE_CYCLES < 1 || WAKE_CYCLES > 4096) begin
            $error("pdfc_top: parameter out of range");
        end
    end

    // ========================================
    // Whole-block state in one struct.
    typedef struct packed {
        pdfc_pkg::pdfc_state_type state;
        logic [11:0]              wake_cnt;
        logic [N_CELLS-1:0]       in_hold;
        logic [N_CELLS-1:0]       ce_hold;
        logic [N_CELLS-1:0]       out_hold;
        logic [N_CELLS-1:0]       oe_hold;
        logic [N_CELLS-1:0]       speed_sel;
        logic                     lock;
        logic [N_CELLS-1:0]       rd_data;
        logic                     rd_valid;
        logic                     rd_refused;
    } pdfc_st_type;

    pdfc_st_type        st_ff;
    pdfc_st_type        nxt_st;
    logic               run_en;
    logic [N_CELLS-1:0] cell_q;
    logic [N_CELLS-1:0] cell_comb;
    logic [N_CELLS-1:0] live_oe;

    // Per-pin output enable from the selected active-low global control.
    function automatic logic [N_CELLS-1:0] oe_map(input logic [N_CELLS-1:0] sel, input logic a_n, input logic b_n);
        oe_map = (~sel & {N_CELLS{~a_n}}) | (sel & {N_CELLS{~b_n}});
    endfunction

    // Cells advance in the run and wake states; during wake the inputs are live again.
    assign run_en  = (st_ff.state == pdfc_pkg::PDFC_RUN) ||
                     (st_ff.state == pdfc_pkg::PDFC_WAKE);
    assign live_oe = oe_map(oe_sel_b, tristate_control_a_n, tristate_control_b_n);

    // ========================================
    // Macrocell bank.
    genvar gi;
    generate
        for (gi = 0; gi < N_CELLS; gi = gi + 1) begin : g_cell
            pdfc_cell u_cell (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .run_en     (run_en),
                .high_speed (st_ff.speed_sel[gi]),
                .d_in       (st_ff.in_hold[gi]),
                .user_ce    (st_ff.ce_hold[gi]),
                .q_out      (cell_q[gi]),
                .comb_out   (cell_comb[gi])
            );
        end
    endgenerate

    // ========================================
    // Sequencer, input capture, pin hold and configuration.
    always_comb begin
        nxt_st            = st_ff;
        nxt_st.rd_valid   = 1'b0;
        nxt_st.rd_refused = 1'b0;
        case (st_ff.state)
            pdfc_pkg::PDFC_RUN: begin
                nxt_st.in_hold  = user_in;
                nxt_st.ce_hold  = user_ce;
                nxt_st.out_hold = cell_q ^ cell_comb;
                nxt_st.oe_hold  = live_oe;
                if (!sleep_request_n) begin
                    // Last capture already stands; freeze from here.
                    nxt_st.state = pdfc_pkg::PDFC_ENTER;
                    nxt_st.in_hold  = st_ff.in_hold;
                    nxt_st.ce_hold  = st_ff.ce_hold;
                end
            end
            pdfc_pkg::PDFC_ENTER: begin
                nxt_st.state = pdfc_pkg::PDFC_SLEEP;
            end
            pdfc_pkg::PDFC_SLEEP: begin
                // Held values untouched; inputs and clocks are not looked at.
                if (sleep_request_n) begin
                    nxt_st.state    = pdfc_pkg::PDFC_WAKE;
                    nxt_st.wake_cnt = 12'(WAKE_CYCLES - 1);
                end
            end
            pdfc_pkg::PDFC_WAKE: begin
                nxt_st.in_hold  = user_in;
                nxt_st.ce_hold  = user_ce;
                if (!sleep_request_n) begin
                    nxt_st.state = pdfc_pkg::PDFC_ENTER;
                end else if (st_ff.wake_cnt == 12'h0000) begin
                    nxt_st.state = pdfc_pkg::PDFC_RUN;
                end else begin
                    nxt_st.wake_cnt = st_ff.wake_cnt - 12'h0001;
                end
            end
            default: begin
                nxt_st.state = pdfc_pkg::PDFC_RUN;
            end
        endcase
        // Configuration writes; erase returns speed select to its reset value (all high-speed) and clears the lock.
        if (cfg_erase) begin
            nxt_st.speed_sel = {N_CELLS{`PDFC_RST_SPEED_SEL}};
            nxt_st.lock      = 1'b0;
        end else begin
            if (cfg_wr) begin
                nxt_st.speed_sel = cfg_speed_sel;
            end
            if (cfg_lock_set) begin
                nxt_st.lock = 1'b1;
            end
        end
        // Readback is refused while locked.
        if (cfg_rd) begin
            nxt_st.rd_valid   = ~st_ff.lock;
            nxt_st.rd_refused = st_ff.lock;
            nxt_st.rd_data    = st_ff.lock ? '0 : st_ff.speed_sel;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff           <= '0;
            st_ff.state     <= pdfc_pkg::PDFC_RUN;
            st_ff.speed_sel <= {N_CELLS{`PDFC_RST_SPEED_SEL}};
            st_ff.lock      <= `PDFC_RST_LOCK;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Pins show the held drive and enable, frozen outside the run state.
    assign pin_out        = st_ff.out_hold;
    assign pin_oe         = st_ff.oe_hold;
    assign cfg_rd_data    = st_ff.rd_data;
    assign cfg_rd_valid   = st_ff.rd_valid;
    assign cfg_rd_refused = st_ff.rd_refused;
    assign asleep         = (st_ff.state == pdfc_pkg::PDFC_SLEEP) ||
                            (st_ff.state == pdfc_pkg::PDFC_ENTER);
endmodule

//--- pdfc_properties.sv
/* Concurrent checks on the ports of the freeze control top, bound to every instance.
   Assumes one clock domain and the asynchronous active-high reset. */
`timescale 1ns/100ps
module pdfc_properties #(
    parameter int N_CELLS = 8
) (
    // Watched ports.
    input wire logic               clk_sys,
    input wire logic               rst,
    input wire logic               sleep_request_n,
    input wire logic               asleep,
    input wire logic [N_CELLS-1:0] user_in,
    input wire logic [N_CELLS-1:0] pin_out,
    input wire logic [N_CELLS-1:0] pin_oe,
    input wire logic               cfg_lock_set,
    input wire logic               cfg_erase,
    input wire logic               cfg_rd,
    input wire logic [N_CELLS-1:0] cfg_rd_data,
    input wire logic               cfg_rd_valid,
    input wire logic               cfg_rd_refused
);
    // ========================================
    // Lock shadow; erase wins over a lock set in the same cycle.
    logic lock_ff;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            lock_ff <= 1'b0;
        else
            lock_ff <= !cfg_erase && (lock_ff || cfg_lock_set);
    end
    // One clock for all checks; reset silences them.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sleep_enter_a: assert property (!sleep_request_n |=> asleep) else $error("sleep request not taken");
    pins_hold_a: assert property (asleep && $past(asleep) |-> $stable(pin_out)) else $error("pin moved asleep");
    oe_hold_a: assert property (asleep && $past(asleep) |-> $stable(pin_oe)) else $error("enable moved asleep");
    input_blind_a: assert property (asleep && $past(asleep) && user_in != $past(user_in)
        |-> $stable(pin_out) && $stable(pin_oe)) else $error("input toggle leaked while asleep");
    wake_exit_a: assert property (asleep && sleep_request_n |-> ##[1:3] !asleep) else $error("wake not taken");
    rd_quiet_a: assert property (!cfg_rd |=> !cfg_rd_valid && !cfg_rd_refused) else $error("stray read answer");
    rd_open_a: assert property (cfg_rd && !lock_ff |=> cfg_rd_valid && !cfg_rd_refused) else $error("read refused");
    rd_lock_a: assert property (cfg_rd && lock_ff |=> cfg_rd_refused && !cfg_rd_valid && cfg_rd_data == '0)
        else $error("locked read leaked data");
endmodule
bind pdfc_top pdfc_properties #(.N_CELLS(N_CELLS)) u_props (.clk_sys, .rst, .sleep_request_n, .asleep,
    .user_in, .pin_out, .pin_oe, .cfg_lock_set, .cfg_erase, .cfg_rd, .cfg_rd_data, .cfg_rd_valid, .cfg_rd_refused);

//--- pdfc_ctrl_model.sv
/* Board controller model: sequences output enables, clock gating and the sleep pin.
   Assumes the bench asks for sleep, floating pins and enables by level inputs. */
`timescale 1ns/100ps
module pdfc_ctrl_model #(
    parameter int GAP = 6
) (
    // Clock, reset and bench requests.
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic want_sleep,
    input  wire logic want_hiz,
    input  wire logic oe_on,
    // Controls into the block.
    output logic      sleep_request_n,
    output logic      tristate_control_a_n,
    output logic      tristate_control_b_n,
    output logic      ce_open
);
    // ========================================
    // Depth 0 awake, 1 pins floated, 2 clocks gated, 3 asleep; one step a cycle, but waking holds depth 2 for the gap.
    // The gap counter is four bits wide, so GAP must stay below 16.
    logic [1:0] dep_ff;
    logic [3:0] gap_ff;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dep_ff <= 2'h0;
            gap_ff <= 4'h0;
        end else if (want_sleep) begin
            gap_ff <= 4'h0;
            if (dep_ff != 2'h3) dep_ff <= dep_ff + 2'h1;
        end else if (dep_ff != 2'h0) begin
            gap_ff <= gap_ff + 4'h1;
            // Clocks stay gated through the wake delay, so no edge lands inside it.
            if (dep_ff != 2'h2 || gap_ff >= GAP) dep_ff <= dep_ff - 2'h1;
        end
    end
    // Sleep only at full depth; enables fall first when the pins must float.
    assign sleep_request_n      = (dep_ff != 2'h3);
    assign ce_open              = (dep_ff < 2'h2);
    assign tristate_control_a_n = !(oe_on && !(want_hiz && dep_ff != 2'h0));
    assign tristate_control_b_n = tristate_control_a_n;
endmodule

//--- test_power_down_freeze_control.sv
/* Self-checking bench for the freeze control top driven by the controller model.
   Assumes the design files and the configuration header are compiled first. */
`timescale 1ns/100ps
`include "pdfc_cfg.svh"
module test_power_down_freeze_control;
    // ========================================
    // Stimulus, design outputs and tallies.
    logic       clk_sys = 1'b0, rst = 1'b1, want_sleep = 1'b0, want_hiz = 1'b0, oe_on = 1'b0, ce_on = 1'b0;
    logic       cfg_wr = 1'b0, lock_set = 1'b0, erase = 1'b0, cfg_rd = 1'b0;
    logic [7:0] user_in = 8'h00, oe_sel_b = 8'h0F, spd = 8'hFF, pin_out, pin_oe, rd_data;
    logic       sleep_n, ta_n, tb_n, ce_open, rd_valid, rd_refused, asleep;
    int         error_cnt = 0, comparisons = 0;
    // Half period of 2.5 ns gives the 200 MHz clock.
    always #2.5 clk_sys = ~clk_sys;
    pdfc_ctrl_model #(.GAP(6)) u_ctrl (.clk_sys, .rst, .want_sleep, .want_hiz, .oe_on, .ce_open,
        .sleep_request_n(sleep_n), .tristate_control_a_n(ta_n), .tristate_control_b_n(tb_n));
    pdfc_top #(.N_CELLS(8), .WAKE_CYCLES(4)) dut (.clk_sys, .rst, .sleep_request_n(sleep_n),
        .tristate_control_a_n(ta_n), .tristate_control_b_n(tb_n), .user_in, .oe_sel_b, .pin_out, .pin_oe,
        .user_ce({8{ce_on & ce_open}}), .cfg_wr, .cfg_speed_sel(spd), .cfg_lock_set(lock_set),
        .cfg_erase(erase), .cfg_rd, .cfg_rd_data(rd_data), .cfg_rd_valid(rd_valid),
        .cfg_rd_refused(rd_refused), .asleep);
    // Compare one value and tally it.
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded wait until the pins match (or leave) a pattern; running out ends the run.
    task automatic wait_pin(input logic [7:0] exp, input bit differ, input string what);
        int n;
        n = 0;
        while (((pin_out === exp) == differ) && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 40) begin
            chk(what, pin_out, differ ? ~exp : exp);
            results();
        end else begin
            comparisons++;
        end
    endtask
    // One config pulse {write, lock, erase}, then a read judged while its one-cycle answer stands.
    task automatic cfg_op(input logic [2:0] ctl, input logic [7:0] exp, input logic refused);
        @(negedge clk_sys) {cfg_wr, lock_set, erase} = ctl;
        @(negedge clk_sys) {cfg_wr, lock_set, erase, cfg_rd} = 4'h1;
        @(negedge clk_sys) cfg_rd = 1'b0;
        chk("read data", rd_data, exp);
        chk("read answer", {6'h00, rd_refused, rd_valid}, {6'h00, refused, !refused});
    endtask
    // Inputs flipped while asleep must not reach the pins until wake.
    task automatic t_freeze();
        logic [7:0] p;
        oe_on = 1'b1;
        user_in = 8'h33;
        repeat (8) @(negedge clk_sys);
        p = pin_out;
        chk("enables on", pin_oe, 8'hFF);
        want_sleep = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk("asleep", {7'h00, asleep}, 8'h01);
        repeat (9) @(negedge clk_sys) user_in = ~user_in;
        chk("frozen pins", pin_out, p);
        chk("frozen enables", pin_oe, 8'hFF);
        want_sleep = 1'b0;
        wait_pin(p ^ 8'hFF, 1'b0, "pins after wake");
    endtask
    // Pins floated before sleep stay floated though enables return while asleep.
    task automatic t_float();
        want_hiz = 1'b1;
        want_sleep = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk("floated", pin_oe, 8'h00);
        want_hiz = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("still floated", pin_oe, 8'h00);
        want_sleep = 1'b0;
        repeat (20) @(negedge clk_sys);
        chk("enables back", pin_oe, 8'hFF);
    endtask
    // Cell 1 in low power must trail cell 0 by the adder; then the clock enable opens.
    task automatic t_lowpower();
        logic [7:0] p;
        int t0, t1;
        t0 = 0;
        t1 = 0;
        spd = 8'hFD;
        cfg_op(3'h4, 8'hFD, 1'b0);
        p = pin_out;
        user_in = ~user_in;
        for (int i = 1; i <= 12; i++) begin
            @(negedge clk_sys);
            if (t0 == 0 && pin_out[0] !== p[0]) t0 = i;
            if (t1 == 0 && pin_out[1] !== p[1]) t1 = i;
        end
        chk("delay adder", 8'(t1 - t0), 8'(`PDFC_LP_CYCLES));
        p = pin_out;
        ce_on = 1'b1;
        wait_pin(p, 1'b1, "clock enable opens");
        ce_on = 1'b0;
    endtask
    // Reset for 12 cycles, then each scenario in turn.
    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        cfg_op(3'h0, 8'hFF, 1'b0);
        spd = 8'hA5;
        cfg_op(3'h4, 8'hA5, 1'b0);
        cfg_op(3'h2, 8'h00, 1'b1);
        cfg_op(3'h1, 8'hFF, 1'b0);
        t_freeze();
        t_float();
        t_lowpower();
        results();
    end
endmodule
